// ### src/trace_sync_pkg.sv
package trace_sync_pkg;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 6;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BUF_PTR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_BUF_STAT = 8'h0c;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FLT_LSB = 1;
   localparam int BSTAT_ABORT_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] EL_USER = 2'h0;
   localparam logic [1:0] EL_KERNEL = 2'h1;
   localparam logic [1:0] EL_HYP = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TSB = 2'b01,
      ST_DSB = 2'b11
   } bar_state_t;

   // Filter bits: kernel, user, hyp, hosted user
   typedef struct packed {
      logic hosted_user_trace_enable;
      logic hyp_trace_enable;
      logic user_trace_enable;
      logic kernel_trace_enable;
   } filter_t;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

   typedef struct packed {
      logic context_sync_event;
      logic cse_prohibited;
      logic trace_sync_barrier;
      logic data_sync_barrier;
      logic filter_adopt;
      logic [1:0] el;
      logic host;
      logic core_mem_idle;
   } pipe_ev_t;

   typedef struct packed {
      logic res_req;
      logic spec_req;
      logic op_done;
      logic mem_issue;
      logic mem_done;
      logic ptr_wr;
      logic [31:0] ptr_val;
      logic abort;
      logic wr_done;
   } trace_ev_t;

   typedef struct packed {
      logic res_grant;
      logic spec_grant;
      logic paused;
      logic mem_go;
      logic tsb_done;
      logic sync_event;
      logic dsb_done;
      filter_t filter_live;
   } ctl_out_t;
endpackage

// ### src/pending_counter.sv
`timescale 1ns/100ps
module pending_counter
   import trace_sync_pkg::*;
#(
   parameter int W = CNT_W
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic inc,
   input wire logic dec,
   output logic idle
);
   logic [W-1:0] cnt_r;

   // Saturates both ways so a stray completion cannot wrap the count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_r <= '0;
      else if (inc && !dec && cnt_r != '1)
         cnt_r <= cnt_r + W'(1);
      else if (dec && !inc && cnt_r != '0)
         cnt_r <= cnt_r - W'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         idle <= 1'b1;
      else if (inc && !dec)
         idle <= 1'b0;
      else if (dec && !inc)
         idle <= (cnt_r <= W'(1));
   end
endmodule

// ### src/axil_slave.sv
`timescale 1ns/100ps
module axil_slave
   import trace_sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire axil_req_t req,
   output axil_rsp_t rsp,
   input wire logic wr_hold,
   input wire logic wr_err,
   input wire logic rd_err,
   input wire logic [31:0] rd_data,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic rd_en,
   output logic [ADDR_W-1:0] rd_addr
);
   logic aw_full_r;
   logic w_full_r;
   logic ar_full_r;

   assign wr_en = aw_full_r && w_full_r && !rsp.bvalid && !wr_hold;
   assign rd_en = ar_full_r && !rsp.rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         rsp.awready <= 1'b1;
         rsp.wready <= 1'b1;
         rsp.bvalid <= 1'b0;
         rsp.bresp <= RESP_OKAY;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end
      else
      begin
         if (req.awvalid && rsp.awready)
         begin
            aw_full_r <= 1'b1;
            rsp.awready <= 1'b0;
            wr_addr <= req.awaddr;
         end
         if (req.wvalid && rsp.wready)
         begin
            w_full_r <= 1'b1;
            rsp.wready <= 1'b0;
            wr_data <= req.wdata;
            wr_strb <= req.wstrb;
         end
         if (wr_en)
         begin
            rsp.bvalid <= 1'b1;
            rsp.bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end
         // Channels reopen only once the response is taken: one write at a time
         if (rsp.bvalid && req.bready)
         begin
            rsp.bvalid <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            rsp.awready <= 1'b1;
            rsp.wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_full_r <= 1'b0;
         rsp.arready <= 1'b1;
         rsp.rvalid <= 1'b0;
         rsp.rdata <= '0;
         rsp.rresp <= RESP_OKAY;
         rd_addr <= '0;
      end
      else
      begin
         if (req.arvalid && rsp.arready)
         begin
            ar_full_r <= 1'b1;
            rsp.arready <= 1'b0;
            rd_addr <= req.araddr;
         end
         if (rd_en)
         begin
            rsp.rvalid <= 1'b1;
            rsp.rdata <= rd_data;
            rsp.rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
         end
         if (rsp.rvalid && req.rready)
         begin
            rsp.rvalid <= 1'b0;
            ar_full_r <= 1'b0;
            rsp.arready <= 1'b1;
         end
      end
   end
endmodule

// ### src/trace_sync_ordering.sv
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module trace_sync_ordering
   import trace_sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire axil_req_t axil_req,
   output axil_rsp_t axil_rsp,
   input wire pipe_ev_t pipe,
   input wire trace_ev_t trc,
   output ctl_out_t ctl
);
   function automatic logic el_traced(input filter_t f, input logic [1:0] el, input logic host);
      logic r;
      r = 1'b0;
      if (el == EL_USER)
         r = host ? f.hosted_user_trace_enable : f.user_trace_enable;
      else if (el == EL_KERNEL)
         r = f.kernel_trace_enable;
      else if (el == EL_HYP)
         r = f.hyp_trace_enable;
      return r;
   endfunction

   bar_state_t state_r;
   bar_state_t state_nxt;
   logic enable_r;
   filter_t filter_sw_r;
   logic prohibited_r;
   logic blocked_r;
   logic tsb_prohib_r;
   logic ptr_dirty_r;
   logic ptr_stage_v_r;
   logic [31:0] ptr_stage_r;
   logic [31:0] ptr_live_r;
   logic [31:0] ptr_vis_r;
   logic abort_pend_r;
   logic abort_flag_r;
   logic ops_idle;
   logic mem_idle;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic wr_err;
   logic rd_err;
   logic wr_hold;
   logic tsb_fin;
   logic dsb_fin;
   logic quiet;
   logic traced_el;

   assign quiet = ctl.paused || blocked_r;
   assign traced_el = el_traced(ctl.filter_live, pipe.el, pipe.host);
   // Direct writes issued behind a trace barrier are held on the bus until it finishes
   assign wr_hold = (state_r == ST_TSB);
   assign wr_err = !(wr_addr == OFS_CTRL || wr_addr == OFS_BUF_PTR || wr_addr == OFS_BUF_STAT);
   assign rd_err = !(rd_addr == OFS_CTRL || rd_addr == OFS_STATUS
                     || rd_addr == OFS_BUF_PTR || rd_addr == OFS_BUF_STAT);

   axil_slave u_bus
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .req(axil_req),
      .rsp(axil_rsp),
      .wr_hold(wr_hold),
      .wr_err(wr_err),
      .rd_err(rd_err),
      .rd_data(rd_data),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_en(),
      .rd_addr(rd_addr)
   );

   pending_counter #(.W(CNT_W)) u_ops
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .inc(ctl.res_grant || ctl.spec_grant),
      .dec(trc.op_done),
      .idle(ops_idle)
   );

   pending_counter #(.W(CNT_W)) u_mem
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .inc(trc.mem_issue),
      .dec(trc.mem_done),
      .idle(mem_idle)
   );

   always_comb
   begin
      rd_data = 32'h0000_0000;
      unique case (rd_addr)
         OFS_CTRL:
            rd_data = {27'h000_0000, filter_sw_r, enable_r};
         OFS_STATUS:
            rd_data = {23'h00_0000, abort_pend_r, mem_idle, ops_idle, tsb_prohib_r,
                       prohibited_r, blocked_r, ctl.paused, state_r};
         OFS_BUF_PTR:
            rd_data = ptr_vis_r;
         OFS_BUF_STAT:
            rd_data = {31'h0000_0000, abort_flag_r};
         default:
            rd_data = 32'h0000_0000;
      endcase
   end

   // Control register: unit enable and software copy of the filter bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enable_r <= CTRL_RST[CTRL_EN_BIT];
         filter_sw_r <= CTRL_RST[CTRL_FLT_LSB +: 4];
      end
      else if (wr_en && wr_addr == OFS_CTRL && wr_strb[0])
      begin
         enable_r <= wr_data[CTRL_EN_BIT];
         filter_sw_r <= wr_data[CTRL_FLT_LSB +: 4];
      end
   end

   // Live filter only moves forward to the new value, never back, so a
   // mid-stream switch is clean for every instruction that follows
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctl.filter_live <= CTRL_RST[CTRL_FLT_LSB +: 4];
      else if (pipe.context_sync_event || pipe.filter_adopt)
         ctl.filter_live <= filter_sw_r;
   end

   // Region tracking and pausing of the trace resources
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prohibited_r <= 1'b0;
         ctl.paused <= 1'b0;
      end
      else if (pipe.context_sync_event)
      begin
         prohibited_r <= pipe.cse_prohibited;
         // Pause takes effect at the event itself, so no resource operation
         // can slip in after a switch to prohibited, and none resumes early
         ctl.paused <= enable_r && pipe.cse_prohibited;
      end
   end

   // Enabling while prohibited leaves the unit silent until an allowed region
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         blocked_r <= 1'b0;
      else if (pipe.context_sync_event && !pipe.cse_prohibited)
         blocked_r <= 1'b0;
      else if (wr_en && wr_addr == OFS_CTRL && wr_strb[0] && wr_data[CTRL_EN_BIT]
               && !enable_r && prohibited_r)
         blocked_r <= 1'b1;
   end

   // Grants; new operations are also held off during a barrier so the
   // barrier closes on a fixed set and cannot be starved by a stream
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl.res_grant <= 1'b0;
         ctl.spec_grant <= 1'b0;
      end
      else
      begin
         ctl.res_grant <= trc.res_req && enable_r && !quiet && !prohibited_r
                          && traced_el && state_r == ST_IDLE;
         ctl.spec_grant <= trc.spec_req && enable_r && !blocked_r && !prohibited_r
                           && traced_el && state_r == ST_IDLE;
      end
   end

   // Barrier sequencer
   always_comb
   begin
      state_nxt = state_r;
      tsb_fin = 1'b0;
      dsb_fin = 1'b0;
      unique case (state_r)
         ST_IDLE:
         begin
            if (pipe.trace_sync_barrier)
               state_nxt = ST_TSB;
            else if (pipe.data_sync_barrier)
               state_nxt = ST_DSB;
         end
         ST_TSB:
         begin
            if (ops_idle && !ctl.res_grant && !ctl.spec_grant)
            begin
               tsb_fin = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_DSB:
         begin
            if (pipe.core_mem_idle && (mem_idle || !tsb_prohib_r))
            begin
               dsb_fin = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl.tsb_done <= 1'b0;
         ctl.sync_event <= 1'b0;
         ctl.dsb_done <= 1'b0;
      end
      else
      begin
         ctl.tsb_done <= tsb_fin;
         ctl.sync_event <= tsb_fin;
         ctl.dsb_done <= dsb_fin;
      end
   end

   // Remembers that the last trace barrier ran in a prohibited region, until a data barrier finishes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tsb_prohib_r <= 1'b0;
      else if (tsb_fin)
         tsb_prohib_r <= prohibited_r;
      else if (dsb_fin)
         tsb_prohib_r <= 1'b0;
   end

   // Trace memory traffic waits out a data barrier in progress
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctl.mem_go <= 1'b0;
      else
         ctl.mem_go <= (state_nxt != ST_DSB);
   end

   // Buffer pointer: trace-side value and software-visible value. A trace
   // write in the same cycle as a direct write is the later one and wins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ptr_live_r <= PTR_RST;
      else if (trc.ptr_wr)
         ptr_live_r <= trc.ptr_val;
      else if (wr_en && wr_addr == OFS_BUF_PTR)
         ptr_live_r <= wr_data;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ptr_dirty_r <= 1'b0;
      else if (trc.ptr_wr)
         ptr_dirty_r <= 1'b1;
      else if (tsb_fin || (wr_en && wr_addr == OFS_BUF_PTR))
         ptr_dirty_r <= 1'b0;
   end

   // Trace writes become visible to direct reads only after a barrier
   // followed by a sync event; this costs read freshness, not correctness
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ptr_stage_v_r <= 1'b0;
         ptr_stage_r <= PTR_RST;
      end
      else if (tsb_fin && ptr_dirty_r)
      begin
         ptr_stage_v_r <= 1'b1;
         ptr_stage_r <= ptr_live_r;
      end
      else if (pipe.context_sync_event || (wr_en && wr_addr == OFS_BUF_PTR))
         ptr_stage_v_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ptr_vis_r <= PTR_RST;
      else if (wr_en && wr_addr == OFS_BUF_PTR)
         ptr_vis_r <= wr_data;
      else if (pipe.context_sync_event && ptr_stage_v_r)
         ptr_vis_r <= ptr_stage_r;
   end

   // Abort on a trace data write is held until that write has finished
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         abort_pend_r <= 1'b0;
      else if (trc.wr_done)
         abort_pend_r <= 1'b0;
      else if (trc.abort)
         abort_pend_r <= 1'b1;
   end

   // Hardware set beats a software clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         abort_flag_r <= 1'b0;
      else if (trc.wr_done && (abort_pend_r || trc.abort))
         abort_flag_r <= 1'b1;
      else if (wr_en && wr_addr == OFS_BUF_STAT && wr_strb[0])
         abort_flag_r <= wr_data[BSTAT_ABORT_BIT];
   end
endmodule

// ### dv/trace_sync_props.sv
`timescale 1ns/100ps
module trace_sync_props
   import trace_sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire axil_req_t axil_req,
   input wire axil_rsp_t axil_rsp,
   input wire pipe_ev_t pipe,
   input wire trace_ev_t trc,
   input wire ctl_out_t ctl
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Mirrors the region the pipeline last announced; grants lag it by one cycle
   logic prohib_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prohib_r <= 1'h0;
      else if (pipe.context_sync_event)
         prohib_r <= pipe.cse_prohibited;
   end

   pause_gate_a: assert property (ctl.paused |=> !ctl.res_grant)
      else $error("resource grant while paused");
   grant_cause_a: assert property (ctl.res_grant |-> $past(trc.res_req))
      else $error("resource grant without request");
   pause_cause_a: assert property ($rose(ctl.paused) |-> $past(pipe.context_sync_event && pipe.cse_prohibited))
      else $error("pause without sync event into prohibited region");
   resume_a: assert property (pipe.context_sync_event && !pipe.cse_prohibited |=> !ctl.paused)
      else $error("still paused in allowed region");
   prohib_quiet_a: assert property (prohib_r |=> !(ctl.res_grant || ctl.spec_grant))
      else $error("grant in prohibited region");
   sync_pair_a: assert property (ctl.tsb_done |-> ctl.sync_event ##1 !ctl.tsb_done)
      else $error("barrier finish without single sync event");
   dsb_wait_a: assert property (ctl.dsb_done |-> $past(pipe.core_mem_idle))
      else $error("data barrier done while core busy");
   mem_hold_a: assert property ($fell(ctl.mem_go) |-> $past(pipe.data_sync_barrier))
      else $error("trace memory stopped without barrier");
   read_lat_a: assert property (axil_req.arvalid && axil_rsp.arready |-> ##[1:2] axil_rsp.rvalid)
      else $error("read answer late");

   cover property (ctl.tsb_done);
   cover property ($rose(ctl.paused));
   cover property (ctl.dsb_done);
endmodule

// ### dv/pipe_model.sv
`timescale 1ns/100ps
module pipe_model
   import trace_sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] go,
   input wire logic prohib,
   input wire logic [1:0] el,
   output pipe_ev_t pipe
);
   // Stores issued ahead of a barrier keep the core busy, so the barrier must wait
   logic [2:0] busy_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         busy_r <= 3'h0;
      else if (go[4])
         busy_r <= 3'h5;
      else if (busy_r != 3'h0)
         busy_r <= busy_r - 3'h1;
   end
   assign pipe = {go[0], prohib, go[1], go[2], go[3], el, 1'h0, busy_r == 3'h0};
endmodule

// ### dv/trace_sync_ordering_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t line %0d", $time, `__LINE__); end end
module trace_sync_ordering_tb
   import trace_sync_pkg::*;
;
   localparam int E_CSE = 0;
   localparam int E_TSB = 1;
   localparam int E_DSB = 2;
   localparam int E_ADOPT = 3;
   localparam int E_SLOW = 4;
   logic aclk;
   logic aresetn;
   axil_req_t req;
   axil_rsp_t rsp;
   trace_ev_t trc;
   ctl_out_t ctl;
   pipe_ev_t pipe;
   logic [4:0] go;
   logic prohib;
   logic [1:0] el;
   logic tsb_seen;
   logic dsb_seen;
   int bad_count;
   int total_checks;

   trace_sync_ordering dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .pipe(pipe),
      .trc(trc), .ctl(ctl));
   pipe_model partner (.aclk(aclk), .aresetn(aresetn), .go(go), .prohib(prohib), .el(el), .pipe(pipe));

   initial
   begin
      aclk = 1'h0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge ctl.tsb_done)
      tsb_seen = 1'h1;

   always @(posedge ctl.dsb_done)
      dsb_seen = 1'h1;

   task automatic print_verdict;
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic timeout_hit;
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      print_verdict();
   endtask

   task automatic ev(input int k);
      go <= 5'h01 << k;
      @(posedge aclk);
      go <= 5'h00;
   endtask

   // One bus transfer; a spare edge at the end keeps back-to-back calls off the same time step
   task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      if (is_wr)
      begin
         req.awaddr <= a;
         req.wdata <= d;
         req.wstrb <= 4'hf;
         req.awvalid <= 1'h1;
         req.wvalid <= 1'h1;
         req.bready <= 1'h1;
      end
      else
      begin
         req.araddr <= a;
         req.arvalid <= 1'h1;
         req.rready <= 1'h1;
      end
      for (n = 0; n < 60; n++)
      begin
         @(posedge aclk);
         if (rsp.awready)
            req.awvalid <= 1'h0;
         if (rsp.wready)
            req.wvalid <= 1'h0;
         if (rsp.arready)
            req.arvalid <= 1'h0;
         if ((is_wr ? rsp.bvalid : rsp.rvalid) === 1'h1)
            break;
      end
      if (n == 60)
         timeout_hit();
      `CHK(is_wr ? rsp.bresp : rsp.rresp, er)
      if (!is_wr && er == RESP_OKAY)
         `CHK(rsp.rdata, d)
      req.bready <= 1'h0;
      req.rready <= 1'h0;
      @(posedge aclk);
   endtask

   task automatic grant(input logic spec, input logic exp, input logic done);
      if (spec)
         trc.spec_req <= 1'h1;
      else
         trc.res_req <= 1'h1;
      @(posedge aclk);
      trc.spec_req <= 1'h0;
      trc.res_req <= 1'h0;
      @(posedge aclk);
      `CHK(spec ? ctl.spec_grant : ctl.res_grant, exp)
      if (done)
      begin
         trc.op_done <= 1'h1;
         @(posedge aclk);
         trc.op_done <= 1'h0;
      end
   endtask

   task automatic s_regs;
      bus(1'h0, OFS_CTRL, CTRL_RST, RESP_OKAY);
      bus(1'h0, OFS_BUF_PTR, PTR_RST, RESP_OKAY);
      bus(1'h0, 8'h40, 32'h0000_0000, RESP_SLVERR);
      bus(1'h1, 8'h40, 32'hffff_ffff, RESP_SLVERR);
      bus(1'h0, OFS_CTRL, CTRL_RST, RESP_OKAY);
      bus(1'h1, OFS_BUF_PTR, 32'h0000_0a50, RESP_OKAY);
      bus(1'h0, OFS_BUF_PTR, 32'h0000_0a50, RESP_OKAY);
   endtask

   task automatic s_filter;
      bus(1'h1, OFS_CTRL, 32'h0000_0003, RESP_OKAY);
      ev(E_ADOPT);
      @(posedge aclk);
      `CHK(ctl.filter_live, 4'h1)
      grant(1'h0, 1'h1, 1'h1);
      bus(1'h1, OFS_CTRL, 32'h0000_0005, RESP_OKAY);
      `CHK(ctl.filter_live, 4'h1)
      ev(E_CSE);
      @(posedge aclk);
      `CHK(ctl.filter_live, 4'h2)
      grant(1'h0, 1'h0, 1'h0);
      // Only the user level is enabled now: hyp stays dark, user is traced
      el <= EL_HYP;
      grant(1'h0, 1'h0, 1'h0);
      el <= EL_USER;
      grant(1'h0, 1'h1, 1'h1);
      el <= EL_KERNEL;
      bus(1'h1, OFS_CTRL, 32'h0000_001f, RESP_OKAY);
      ev(E_ADOPT);
      @(posedge aclk);
      `CHK(ctl.filter_live, 4'hf)
   endtask

   task automatic s_pause;
      prohib <= 1'h1;
      ev(E_CSE);
      prohib <= 1'h0;
      @(posedge aclk);
      `CHK(ctl.paused, 1'h1)
      grant(1'h0, 1'h0, 1'h0);
      ev(E_CSE);
      @(posedge aclk);
      `CHK(ctl.paused, 1'h0)
      grant(1'h0, 1'h1, 1'h1);
   endtask

   task automatic s_block;
      bus(1'h1, OFS_CTRL, 32'h0000_0000, RESP_OKAY);
      prohib <= 1'h1;
      ev(E_CSE);
      prohib <= 1'h0;
      @(posedge aclk);
      `CHK(ctl.paused, 1'h0)
      bus(1'h1, OFS_CTRL, 32'h0000_001f, RESP_OKAY);
      grant(1'h1, 1'h0, 1'h0);
      ev(E_CSE);
      grant(1'h1, 1'h1, 1'h1);
   endtask

   // An op left outstanding holds the barrier open while a write is attempted
   task automatic s_tsb;
      tsb_seen = 1'h0;
      grant(1'h0, 1'h1, 1'h0);
      trc.ptr_wr <= 1'h1;
      trc.ptr_val <= 32'h0000_1230;
      ev(E_TSB);
      trc.ptr_wr <= 1'h0;
      fork
         begin
            bus(1'h1, OFS_BUF_STAT, 32'h0000_0000, RESP_OKAY);
            `CHK(tsb_seen, 1'h1)
         end
         begin
            repeat (4) @(posedge aclk);
            `CHK(tsb_seen, 1'h0)
            trc.op_done <= 1'h1;
            @(posedge aclk);
            trc.op_done <= 1'h0;
         end
      join
      ev(E_CSE);
      @(posedge aclk);
      bus(1'h0, OFS_BUF_PTR, 32'h0000_1230, RESP_OKAY);
   endtask

   task automatic s_dsb;
      int n;
      ev(E_SLOW);
      @(posedge aclk);
      ev(E_DSB);
      for (n = 0; n < 30; n++)
      begin
         @(posedge aclk);
         if (ctl.dsb_done === 1'h1)
            break;
         if (n == 1)
            `CHK(ctl.mem_go, 1'h0)
      end
      if (n == 30)
         timeout_hit();
      `CHK(n >= 3, 1'h1)
      // Trace memory write left open across a barrier run while prohibited
      prohib <= 1'h1;
      ev(E_CSE);
      prohib <= 1'h0;
      trc.mem_issue <= 1'h1;
      ev(E_TSB);
      trc.mem_issue <= 1'h0;
      repeat (4) @(posedge aclk);
      dsb_seen = 1'h0;
      ev(E_DSB);
      // Barrier waiting, paused, prohibited, ran prohibited, ops idle, memory busy
      bus(1'h0, OFS_STATUS, 32'h0000_0077, RESP_OKAY);
      `CHK(dsb_seen, 1'h0)
      trc.mem_done <= 1'h1;
      @(posedge aclk);
      trc.mem_done <= 1'h0;
      repeat (2) @(posedge aclk);
      `CHK(dsb_seen, 1'h1)
   endtask

   task automatic s_abort;
      trc.abort <= 1'h1;
      @(posedge aclk);
      trc.abort <= 1'h0;
      bus(1'h0, OFS_BUF_STAT, 32'h0000_0000, RESP_OKAY);
      trc.wr_done <= 1'h1;
      @(posedge aclk);
      trc.wr_done <= 1'h0;
      @(posedge aclk);
      bus(1'h0, OFS_BUF_STAT, 32'h0000_0001, RESP_OKAY);
      bus(1'h1, OFS_BUF_STAT, 32'h0000_0000, RESP_OKAY);
      bus(1'h0, OFS_BUF_STAT, 32'h0000_0000, RESP_OKAY);
   endtask

   initial
   begin
      aresetn = 1'h0;
      req = '0;
      trc = '0;
      go = 5'h00;
      prohib = 1'h0;
      el = EL_KERNEL;
      tsb_seen = 1'h0;
      dsb_seen = 1'h0;
      bad_count = 0;
      total_checks = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      s_regs();
      s_filter();
      s_pause();
      s_block();
      s_tsb();
      s_dsb();
      s_abort();
      print_verdict();
   end
endmodule

bind trace_sync_ordering trace_sync_props props (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
   .axil_rsp(axil_rsp), .pipe(pipe), .trc(trc), .ctl(ctl));
